// ==== fbo_regs.svh ====
// Purpose: Register map, field positions, reset values and timing figures of the fuse option block
// Assumes: 32-bit APB words, byte address is four times the register index
// Notes:   Definitions only
`ifndef FBO_REGS_SVH
`define FBO_REGS_SVH

// Register indices, byte address is index times four
`define FBO_IDX_FUSE_TIMING 8'h00
`define FBO_IDX_FUSE_BYTE 8'h01
`define FBO_IDX_FUSE_CMD 8'h02
`define FBO_IDX_DETECT_CUST 8'h1c
`define FBO_IDX_CUST 8'h1e
`define FBO_IDX_OSC 8'h20
`define FBO_IDX_RST_FILT 8'h24
`define FBO_IDX_ADC 8'h34
`define FBO_ADDR(idx) (8'((idx) << 2))

// Fuse timing and command fields
`define FBO_STROBE_LSB 0
`define FBO_HOLD_LSB 8
`define FBO_SETUP_LSB 16
`define FBO_CMD_BUSY_BIT 8
`define FBO_FUSE_ADDR_W 6

// Supply detector config fields (own word, index 0x1c)
`define FBO_DET_LEVEL_LSB 0
`define FBO_DET_EN_BIT 8
`define FBO_DET_IE_BIT 9
`define FBO_DET_RE_BIT 10
`define FBO_DET_OE_BIT 11
`define FBO_DET_UNLOCK_LSB 12
`define FBO_DET_PORRE_BIT 14
`define FBO_DET_FLAG_BIT 15
`define FBO_DET_FUSE_MASK 16'h4403
`define FBO_DET_WR_MASK 16'h4f03

// Customer config fields (own word, index 0x1e)
`define FBO_CUST_PANEL_BIT 0
`define FBO_CUST_RTC_BIT 1
`define FBO_CUST_DEBUG_BIT 2
`define FBO_CUST_FUSE_MASK 16'h0004
`define FBO_CUST_WR_MASK 16'h0007

// Unlock codes
`define FBO_KEY_1 2'b01
`define FBO_KEY_2 2'b10
`define FBO_KEY_3 2'b11
`define FBO_KEY_LOCK 2'b00

// Timing: least fuse phase time and clock period
`define FBO_MIN_PHASE_NS 100
`define FBO_CLK_PERIOD_NS 8
`define FBO_MIN_PHASE_CYC ((`FBO_MIN_PHASE_NS + `FBO_CLK_PERIOD_NS - 1) / `FBO_CLK_PERIOD_NS)
`define FBO_TIMING_RST {8'h00, 8'(`FBO_MIN_PHASE_CYC - 1), 8'(`FBO_MIN_PHASE_CYC - 1), 8'(`FBO_MIN_PHASE_CYC - 1)}

`endif

// ==== fbo_pkg.sv ====
// Purpose: Types of the fuse option block
// Assumes: Constants live in fbo_regs.svh
// Notes:   All block state but the first pin synchroniser stage is one packed struct
package fbo_pkg;

    typedef enum logic [1:0] {
        FS_IDLE,
        FS_SETUP,
        FS_STROBE,
        FS_HOLD
    } fbo_fsm_t;

    typedef struct packed {
        logic [15:0] data;
        logic [3:0] ctrl;
    } fbo_pins_t;

    typedef struct packed {
        // Bus answer and fuse default load flag
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic boot;
        // Registers
        logic [31:0] timing;
        logic [7:0] fuse_byte;
        logic [5:0] fuse_addr;
        logic [15:0] det;
        logic [1:0] unlock_step;
        logic [15:0] cust;
        logic [15:0] osc;
        logic [15:0] rst_filt;
        logic [15:0] adc;
        // Fuse sequencer
        fbo_fsm_t fsm;
        logic [7:0] cnt;
        logic fuse_re;
        logic fuse_strobe;
        // Detector and pins
        logic [2:0] low_sync;
        logic det_out;
        logic irq;
        logic por_req;
        logic det_rst_req;
        logic rtc_reconfig;
        fbo_pins_t pins;
        logic [1:0] dbg_sync;
        logic uart_rxd;
        logic dbg_clk;
        logic dbg_data;
        logic dbg_data_oe;
    } fbo_state_t;

endpackage

// ==== fbo_option_config.sv ====
// Purpose: Fuse read timing, fuse byte read-back and option-byte registers behind APB
// Assumes: srst_i is the power-on reset; fuse macro and fuse defaults are on clk_sys_i
// Notes:   Zero wait state slave, pready is high in the first access cycle
// Behaviour
// - Strobe lasts strobe width field plus one
// - Address and read enable held hold+1 after
// - Address and read enable lead by setup+1
// - Read byte register keeps last fuse byte
// - User mode access errors, changes nothing
// - Reserved locations ignore writes, read zero
// - Low supply flag follows detector level
// - Power-on reset enable causes power-on reset
// - Reset enable alone causes detector reset
// - Unlock sequence 01,10,11 opens other fields
// - While open, 00 relocks, others ignored
// - Output enable gates detector output
// - Interrupt enable gates low supply request
// - Detector enable switches detector, reset clears
// - Threshold select fuse loaded, erased gives 00
// - Fuse loaded bits zero when fuse erased
// - Panel select routes bus pins to RGB
// - RTC permit gates reconfiguration requests
// - Debug disable turns debug pins to UART
`timescale 1ns/1ps
`include "fbo_regs.svh"

module fbo_option_config (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    input wire logic [2:0] pprot_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Fuse defaults, bit valid where the match mask is set
    input wire logic [15:0] fuse_det_value_i,
    input wire logic [15:0] fuse_det_match_i,
    input wire logic [15:0] fuse_cust_value_i,
    input wire logic [15:0] fuse_cust_match_i,
    // Fuse macro
    input wire logic [7:0] fuse_data_i,
    output logic [5:0] fuse_addr_o,
    output logic fuse_read_enable_o,
    output logic fuse_strobe_o,
    // Supply detector
    input wire logic low_supply_i,
    output logic detector_enable_o,
    output logic [1:0] detector_level_o,
    output logic detector_out_o,
    output logic detector_irq_o,
    output logic por_request_o,
    output logic detector_reset_request_o,
    // RTC reconfiguration
    input wire logic rtc_direction_ctrl_a_i,
    input wire logic rtc_direction_ctrl_b_i,
    output logic rtc_reconfig_o,
    // Panel pin mux
    input wire fbo_pkg::fbo_pins_t bus_pins_i,
    input wire fbo_pkg::fbo_pins_t panel_pins_i,
    output fbo_pkg::fbo_pins_t pad_pins_o,
    output logic panel_pins_select_o,
    // Debug and third UART pins
    input wire logic debug_clock_pin_i,
    input wire logic debug_data_pin_i,
    input wire logic dbg_data_out_i,
    input wire logic dbg_data_oe_i,
    input wire logic uart_txd_i,
    output logic debug_data_pin_o,
    output logic debug_data_pin_oe_o,
    output logic dbg_clk_o,
    output logic dbg_data_in_o,
    output logic uart_rxd_o,
    output logic debug_port_disable_o
);

    fbo_pkg::fbo_state_t s_q;
    fbo_pkg::fbo_state_t s_d;

    // Byte lane mask from strobes
    function automatic logic [31:0] lane_mask(input logic [3:0] strb);
        lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction

    // Merge a write into a stored word by lanes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] strb);
        merge = (old & ~lane_mask(strb)) | (wd & lane_mask(strb));
    endfunction

    logic setup_ph;
    logic access_ph;
    logic priv;
    logic wr_go;
    logic [31:0] det_word;
    logic [31:0] new_word;
    logic [1:0] key;
    logic unlocked;
    logic low_s;
    logic low_rise;
    logic [1:0] pin_meta_q;

    // Bus phases; pprot bit 0 marks a privileged master
    assign setup_ph = psel_i && !penable_i;
    assign access_ph = psel_i && penable_i && s_q.pready;
    assign priv = pprot_i[0];
    assign wr_go = access_ph && pwrite_i && priv;
    assign unlocked = (s_q.unlock_step == 2'd3);
    assign low_s = s_q.low_sync[1];
    assign low_rise = s_q.low_sync[1] && !s_q.low_sync[2];
    assign det_word = {16'h0000, s_q.det[15:14], (unlocked ? `FBO_KEY_3 : `FBO_KEY_LOCK), s_q.det[11:0]};
    assign new_word = merge(det_word, pwdata_i, pstrb_i);
    assign key = new_word[`FBO_DET_UNLOCK_LSB +: 2];

    // Next state of the whole block
    always_comb begin
        s_d = s_q;
        s_d.por_req = 1'b0;
        s_d.det_rst_req = 1'b0;

        // Answer is prepared in setup and shown in the first access cycle
        s_d.pready = setup_ph;
        s_d.pslverr = 1'b0;
        s_d.prdata = 32'h0000_0000;
        if (setup_ph) begin
            if (!priv) begin
                s_d.pslverr = 1'b1;
            end else if (!pwrite_i) begin
                case (paddr_i)
                    `FBO_ADDR(`FBO_IDX_FUSE_TIMING): s_d.prdata = s_q.timing;
                    `FBO_ADDR(`FBO_IDX_FUSE_BYTE): s_d.prdata = {24'h00_0000, s_q.fuse_byte};
                    `FBO_ADDR(`FBO_IDX_FUSE_CMD): s_d.prdata = {23'h00_0000, s_q.fsm != fbo_pkg::FS_IDLE,
                                                                 2'b00, s_q.fuse_addr};
                    `FBO_ADDR(`FBO_IDX_DETECT_CUST): s_d.prdata = det_word;
                    `FBO_ADDR(`FBO_IDX_CUST): s_d.prdata = {16'h0000, s_q.cust};
                    `FBO_ADDR(`FBO_IDX_OSC): s_d.prdata = {16'h0000, s_q.osc};
                    `FBO_ADDR(`FBO_IDX_RST_FILT): s_d.prdata = {16'h0000, s_q.rst_filt};
                    `FBO_ADDR(`FBO_IDX_ADC): s_d.prdata = {16'h0000, s_q.adc};
                    default: s_d.prdata = 32'h0000_0000;
                endcase
            end
        end

        // Register writes take effect on the access edge only
        if (wr_go) begin
            case (paddr_i)
                `FBO_ADDR(`FBO_IDX_FUSE_TIMING): s_d.timing = merge(s_q.timing, pwdata_i, pstrb_i) & 32'h00ff_ffff;
                `FBO_ADDR(`FBO_IDX_FUSE_CMD): begin
                    // A start while busy is dropped so the macro timing is never cut short
                    if (pstrb_i[0] && s_q.fsm == fbo_pkg::FS_IDLE) begin
                        s_d.fuse_addr = pwdata_i[`FBO_FUSE_ADDR_W-1:0];
                        s_d.fsm = fbo_pkg::FS_SETUP;
                        s_d.cnt = s_q.timing[`FBO_SETUP_LSB +: 8];
                        s_d.fuse_re = 1'b1;
                    end
                end
                `FBO_ADDR(`FBO_IDX_DETECT_CUST): begin
                    if (unlocked) begin
                        s_d.det = (s_q.det & ~`FBO_DET_WR_MASK) | (new_word[15:0] & `FBO_DET_WR_MASK);
                    end
                    if (pstrb_i[1]) begin
                        if (unlocked) begin
                            if (key == `FBO_KEY_LOCK) begin
                                s_d.unlock_step = 2'd0;
                            end
                        end else begin
                            case (s_q.unlock_step)
                                2'd0: s_d.unlock_step = (key == `FBO_KEY_1) ? 2'd1 : 2'd0;
                                2'd1: s_d.unlock_step = (key == `FBO_KEY_2) ? 2'd2 : 2'd0;
                                2'd2: s_d.unlock_step = (key == `FBO_KEY_3) ? 2'd3 : 2'd0;
                                default: s_d.unlock_step = 2'd0;
                            endcase
                        end
                    end
                end
                `FBO_ADDR(`FBO_IDX_CUST): s_d.cust = 16'(merge({16'h0000, s_q.cust}, pwdata_i, pstrb_i))
                    & `FBO_CUST_WR_MASK;
                `FBO_ADDR(`FBO_IDX_OSC): s_d.osc = 16'(merge({16'h0000, s_q.osc}, pwdata_i, pstrb_i));
                `FBO_ADDR(`FBO_IDX_RST_FILT): s_d.rst_filt = 16'(merge({16'h0000, s_q.rst_filt}, pwdata_i, pstrb_i));
                `FBO_ADDR(`FBO_IDX_ADC): s_d.adc = 16'(merge({16'h0000, s_q.adc}, pwdata_i, pstrb_i));
                default: s_d.fsm = s_q.fsm;
            endcase
        end

        // fuse defaults loaded once after reset
        if (s_q.boot) begin
            s_d.boot = 1'b0;
            s_d.det = fuse_det_value_i & fuse_det_match_i & `FBO_DET_FUSE_MASK;
            s_d.cust = fuse_cust_value_i & fuse_cust_match_i & `FBO_CUST_FUSE_MASK;
        end

        // Fuse read sequencer, each phase lasts field plus one cycles
        case (s_q.fsm)
            fbo_pkg::FS_IDLE: begin
                s_d.fuse_re = s_d.fuse_re;
            end
            fbo_pkg::FS_SETUP: begin
                if (s_q.cnt == 8'h00) begin
                    s_d.fsm = fbo_pkg::FS_STROBE;
                    s_d.fuse_strobe = 1'b1;
                    s_d.cnt = s_q.timing[`FBO_STROBE_LSB +: 8];
                end else begin
                    s_d.cnt = s_q.cnt - 8'h01;
                end
            end
            fbo_pkg::FS_STROBE: begin
                if (s_q.cnt == 8'h00) begin
                    s_d.fsm = fbo_pkg::FS_HOLD;
                    s_d.fuse_strobe = 1'b0;
                    s_d.cnt = s_q.timing[`FBO_HOLD_LSB +: 8];
                    s_d.fuse_byte = fuse_data_i;
                end else begin
                    s_d.cnt = s_q.cnt - 8'h01;
                end
            end
            fbo_pkg::FS_HOLD: begin
                if (s_q.cnt == 8'h00) begin
                    s_d.fsm = fbo_pkg::FS_IDLE;
                    s_d.fuse_re = 1'b0;
                end else begin
                    s_d.cnt = s_q.cnt - 8'h01;
                end
            end
            default: s_d.fsm = fbo_pkg::FS_IDLE;
        endcase

        // Detector level crosses in from the analog side; the third stage is for edges
        s_d.low_sync = {s_q.low_sync[1:0], low_supply_i};
        s_d.det[`FBO_DET_FLAG_BIT] = low_s;
        s_d.det_out = s_q.det[`FBO_DET_OE_BIT] && low_s;
        s_d.irq = s_q.det[`FBO_DET_IE_BIT] && low_s;
        if (low_rise) begin
            s_d.por_req = s_q.det[`FBO_DET_PORRE_BIT];
            s_d.det_rst_req = s_q.det[`FBO_DET_RE_BIT] && !s_q.det[`FBO_DET_PORRE_BIT];
        end

        s_d.rtc_reconfig = s_q.cust[`FBO_CUST_RTC_BIT] && (rtc_direction_ctrl_a_i || rtc_direction_ctrl_b_i);
        s_d.pins = s_q.cust[`FBO_CUST_PANEL_BIT] ? panel_pins_i : bus_pins_i;

        // Debug pins cross in from outside, then route by disable bit
        s_d.dbg_sync = pin_meta_q;
        if (s_q.cust[`FBO_CUST_DEBUG_BIT]) begin
            s_d.uart_rxd = s_q.dbg_sync[0];
            s_d.dbg_clk = 1'b0;
            s_d.dbg_data = uart_txd_i;
            s_d.dbg_data_oe = 1'b1;
        end else begin
            s_d.uart_rxd = 1'b1;
            s_d.dbg_clk = s_q.dbg_sync[0];
            s_d.dbg_data = dbg_data_out_i;
            s_d.dbg_data_oe = dbg_data_oe_i;
        end
    end

    // First synchroniser stage of the pins; only the second stage reads it, never the routing logic
    always_ff @(posedge clk_sys_i) begin
        pin_meta_q <= {debug_data_pin_i, debug_clock_pin_i};
    end

    // State register; reset clears detector enable and relocks
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            s_q <= '0;
            s_q.boot <= 1'b1;
            s_q.unlock_step <= 2'd0;
            s_q.timing <= `FBO_TIMING_RST;
            s_q.uart_rxd <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign detector_enable_o = s_q.det[`FBO_DET_EN_BIT];
    assign detector_level_o = s_q.det[`FBO_DET_LEVEL_LSB +: 2];
    assign prdata_o = s_q.prdata;
    assign pready_o = s_q.pready;
    assign pslverr_o = s_q.pslverr;
    assign fuse_addr_o = s_q.fuse_addr;
    assign fuse_read_enable_o = s_q.fuse_re;
    assign fuse_strobe_o = s_q.fuse_strobe;
    assign detector_out_o = s_q.det_out;
    assign detector_irq_o = s_q.irq;
    assign por_request_o = s_q.por_req;
    assign detector_reset_request_o = s_q.det_rst_req;
    assign rtc_reconfig_o = s_q.rtc_reconfig;
    assign pad_pins_o = s_q.pins;
    assign panel_pins_select_o = s_q.cust[`FBO_CUST_PANEL_BIT];
    assign debug_data_pin_o = s_q.dbg_data;
    assign debug_data_pin_oe_o = s_q.dbg_data_oe;
    assign dbg_clk_o = s_q.dbg_clk;
    assign dbg_data_in_o = s_q.dbg_sync[1];
    assign uart_rxd_o = s_q.uart_rxd;
    assign debug_port_disable_o = s_q.cust[`FBO_CUST_DEBUG_BIT];

    // Sequences of the fuse read
    sequence fuse_start_s;
        wr_go && paddr_i == `FBO_ADDR(`FBO_IDX_FUSE_CMD) && pstrb_i[0] && s_q.fsm == fbo_pkg::FS_IDLE;
    endsequence

    sequence strobe_rise_s;
        $rose(fuse_strobe_o);
    endsequence

    a_strobe_width: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        strobe_rise_s |-> fuse_strobe_o [*1] ##0 (s_q.cnt == s_q.timing[`FBO_STROBE_LSB +: 8]))
        else $error("strobe width count wrong at rise");

    a_hold_after: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        $fell(fuse_strobe_o) |-> fuse_read_enable_o && s_q.cnt == s_q.timing[`FBO_HOLD_LSB +: 8])
        else $error("read enable not held after strobe");

    a_setup_lead: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        fuse_start_s |=> fuse_read_enable_o && !fuse_strobe_o && s_q.cnt == s_q.timing[`FBO_SETUP_LSB +: 8])
        else $error("setup phase not entered");

    a_byte_capture: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        $fell(fuse_strobe_o) |-> s_q.fuse_byte == $past(fuse_data_i))
        else $error("fuse byte not captured");

    a_user_error: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        setup_ph && !priv |=> pslverr_o && pready_o && prdata_o == 32'h0000_0000)
        else $error("user access not refused");

    a_unlock_open: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        s_q.unlock_step == 2'd2 && wr_go && paddr_i == `FBO_ADDR(`FBO_IDX_DETECT_CUST) && pstrb_i[1]
        && key == `FBO_KEY_3 |=> unlocked)
        else $error("unlock sequence did not open");

    a_relock: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        unlocked && wr_go && paddr_i == `FBO_ADDR(`FBO_IDX_DETECT_CUST) && pstrb_i[1]
        && key != `FBO_KEY_LOCK |=> unlocked)
        else $error("non-zero key relocked");

    a_irq_gate: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        detector_irq_o |-> $past(s_q.det[`FBO_DET_IE_BIT]) && $past(low_s))
        else $error("interrupt without enable and low supply");

    a_por_excl: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        !(por_request_o && detector_reset_request_o))
        else $error("both reset requests raised");

endmodule

// ==== fuse_backed_option_config_test.sv ====
// Purpose: Self-checking bench for the fuse option block, driven over APB
// Assumes: Supply config word at byte 0x70, customer config word at byte 0x78
// Notes:   Fuse timing fields set small so the read sequence stays short
`timescale 1ns/1ps

module fuse_backed_option_config_test;
    localparam logic [7:0] a_tim = 8'h00;
    localparam logic [7:0] a_byte = 8'h04;
    localparam logic [7:0] a_cmd = 8'h08;
    localparam logic [7:0] a_cfg = 8'h70;
    localparam logic [7:0] a_cust = 8'h78;
    localparam logic [7:0] a_rsv = 8'hb0;
    logic clk_sys_i, srst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, e;
    logic [7:0] paddr_i, fuse_data_i;
    logic [31:0] pwdata_i, prdata_o, r;
    logic [3:0] pstrb_i;
    logic [2:0] pprot_i;
    logic [15:0] fuse_det_value_i, fuse_det_match_i, fuse_cust_value_i, fuse_cust_match_i;
    logic fuse_read_enable_o, fuse_strobe_o, low_supply_i, detector_enable_o, detector_out_o;
    logic detector_irq_o, por_request_o, detector_reset_request_o;
    logic [1:0] detector_level_o;
    logic rtc_direction_ctrl_a_i, rtc_direction_ctrl_b_i, rtc_reconfig_o, panel_pins_select_o;
    fbo_pkg::fbo_pins_t bus_pins_i, panel_pins_i, pad_pins_o;
    logic debug_clock_pin_i, debug_data_pin_i, dbg_data_out_i, dbg_data_oe_i, uart_txd_i;
    logic debug_data_pin_o, debug_data_pin_oe_o, dbg_clk_o, uart_rxd_o, debug_port_disable_o, dbg_data_in_o;
    logic [5:0] fuse_addr_o;
    int miscompares, num_checks;

    fbo_option_config dut_u (
        .clk_sys_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .pprot_i,
        .prdata_o, .pready_o, .pslverr_o, .fuse_det_value_i, .fuse_det_match_i, .fuse_cust_value_i,
        .fuse_cust_match_i, .fuse_data_i, .fuse_addr_o, .fuse_read_enable_o, .fuse_strobe_o,
        .low_supply_i, .detector_enable_o, .detector_level_o, .detector_out_o, .detector_irq_o,
        .por_request_o, .detector_reset_request_o, .rtc_direction_ctrl_a_i, .rtc_direction_ctrl_b_i,
        .rtc_reconfig_o, .bus_pins_i, .panel_pins_i, .pad_pins_o, .panel_pins_select_o,
        .debug_clock_pin_i, .debug_data_pin_i, .dbg_data_out_i, .dbg_data_oe_i, .uart_txd_i,
        .debug_data_pin_o, .debug_data_pin_oe_o, .dbg_clk_o, .dbg_data_in_o, .uart_rxd_o,
        .debug_port_disable_o
    );

    // Free-running 125 MHz clock
    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    // Compare and count
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        num_checks++;
        if (got !== ex) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask

    // APB transfer; an idle edge first keeps back-to-back calls from colliding
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [2:0] p);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        pstrb_i <= s;
        pprot_i <= p;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        @(posedge clk_sys_i);
        while (pready_o !== 1'b1 && n < 50) begin
            @(posedge clk_sys_i);
            n++;
        end
        if (n == 50) miscompares++;
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        apb(1'b1, a, d, s, 3'b001);
    endtask

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h00000000, 4'h0, 3'b001);
    endtask

    // Power-on values loaded from fuse defaults
    task automatic t_reset();
        rd(a_cfg);
        chk("fuse defaults", 32'h00000403, r);
        rd(a_cust);
        chk("cust defaults", 32'h00000004, r);
        chk("level pins", 32'h00000003, detector_level_o);
        chk("rtc blocked", 32'h00000000, rtc_reconfig_o);
        chk("uart rx", 32'h00000000, uart_rxd_o);
        chk("uart tx pin", 32'h00000003, {debug_data_pin_o, debug_data_pin_oe_o});
    endtask

    // Locked writes ignored, wrong order restarts, right order opens
    task automatic t_unlock();
        wr(a_cfg, 32'h00000f00, 4'h3);
        wr(a_cfg, 32'h00001000, 4'h2);
        wr(a_cfg, 32'h00003000, 4'h2);
        rd(a_cfg);
        chk("locked", 32'h00000403, r);
        wr(a_cfg, 32'h00001000, 4'h2);
        wr(a_cfg, 32'h00002000, 4'h2);
        wr(a_cfg, 32'h00003000, 4'h2);
        rd(a_cfg);
        chk("opened", 32'h00003403, r);
        wr(a_cfg, 32'h00003f02, 4'h3);
        repeat (3) @(posedge clk_sys_i);
        chk("enable level", 32'h00000006, {detector_enable_o, detector_level_o});
    endtask

    // Low supply event: request pulses, gated irq and output, live flag
    task automatic t_detect(input logic [1:0] ex);
        int pc, rc;
        pc = 0;
        rc = 0;
        low_supply_i <= 1'b1;
        repeat (8) begin
            @(posedge clk_sys_i);
            if (por_request_o === 1'b1) pc++;
            if (detector_reset_request_o === 1'b1) rc++;
        end
        chk("por pulses", 32'(ex[1]), pc);
        chk("det pulses", 32'(ex[0]), rc);
        chk("irq out", 32'h00000003, {detector_irq_o, detector_out_o});
        rd(a_cfg);
        chk("flag set", 32'h00000001, r[15]);
        low_supply_i <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
        chk("irq out idle", 32'h00000000, {detector_irq_o, detector_out_o});
        rd(a_cfg);
        chk("flag clear", 32'h00000000, r[15]);
    endtask

    // User mode errors and changes nothing; reserved place reads zero
    task automatic t_user();
        apb(1'b1, a_cfg, 32'h00000000, 4'hf, 3'b000);
        chk("user error", 32'h00000001, e);
        rd(a_cfg);
        chk("user unchanged", 32'h00007f02, r);
        chk("super no error", 32'h00000000, e);
        wr(a_rsv, 32'hffffffff, 4'hf);
        rd(a_rsv);
        chk("reserved", 32'h00000000, r);
    endtask

    // Fuse read phases: setup 3, strobe 1, hold 2 give 4, 2 and 3 cycles
    task automatic t_fuse();
        int su, st, ho;
        su = 0;
        st = 0;
        ho = 0;
        wr(a_tim, 32'h00030201, 4'h7);
        fuse_data_i <= 8'ha5;
        wr(a_cmd, 32'h0000002a, 4'h1);
        repeat (40) begin
            @(posedge clk_sys_i);
            if (fuse_strobe_o === 1'b1) st++;
            else if (fuse_read_enable_o === 1'b1 && st == 0) su++;
            else if (fuse_read_enable_o === 1'b1) ho++;
        end
        chk("setup cycles", 32'h00000004, su);
        chk("strobe cycles", 32'h00000002, st);
        chk("hold cycles", 32'h00000003, ho);
        chk("fuse addr", 32'h0000002a, fuse_addr_o);
        rd(a_byte);
        chk("fuse byte", 32'h000000a5, r);
    endtask

    // Customer config: panel routing, rtc permit, debug pins back
    task automatic t_pins();
        chk("bus pins", {16'h1234, 4'h5}, pad_pins_o);
        wr(a_cust, 32'h00000003, 4'h1);
        debug_clock_pin_i <= 1'b1;
        debug_data_pin_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        chk("panel pins", {16'hbeef, 4'ha}, pad_pins_o);
        chk("rtc and panel", 32'h00000003, {rtc_reconfig_o, panel_pins_select_o});
        chk("debug pins", 32'h00000005, {dbg_clk_o, debug_port_disable_o, dbg_data_in_o});
        chk("uart rx idle", 32'h00000001, uart_rxd_o);
        rd(a_cust);
        chk("cust written", 32'h00000003, r);
    endtask

    // Other keys keep it open, 00 relocks, later writes ignored
    task automatic t_relock();
        wr(a_cfg, 32'h00006f02, 4'h2);
        rd(a_cfg);
        chk("stays open", 32'h00007f02, r);
        wr(a_cfg, 32'h00004f02, 4'h2);
        wr(a_cfg, 32'h00000000, 4'h3);
        rd(a_cfg);
        chk("relocked", 32'h00004f02, r);
        chk("enable kept", 32'h00000001, detector_enable_o);
    endtask

    task automatic final_report();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Watchdog, the run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        miscompares++;
        final_report();
    end

    // Main sequence
    initial begin
        {srst_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, pstrb_i} = {1'b1, 47'h0};
        pprot_i = 3'b001;
        fuse_det_value_i = 16'hffff;
        fuse_det_match_i = 16'h0403;
        fuse_cust_value_i = 16'hffff;
        fuse_cust_match_i = 16'h0004;
        {fuse_data_i, low_supply_i, debug_clock_pin_i, debug_data_pin_i} = 11'h000;
        {rtc_direction_ctrl_a_i, rtc_direction_ctrl_b_i, uart_txd_i} = 3'b101;
        {dbg_data_out_i, dbg_data_oe_i} = 2'b00;
        bus_pins_i = {16'h1234, 4'h5};
        panel_pins_i = {16'hbeef, 4'ha};
        repeat (12) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        t_reset();
        t_unlock();
        t_detect(2'b01);
        wr(a_cfg, 32'h00007f02, 4'h3);
        t_detect(2'b10);
        t_user();
        t_fuse();
        t_pins();
        t_relock();
        final_report();
    end
endmodule
